/* bench/grf_front_model.sv */
module grf_front_model (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // sample taken by the block
    input wire logic sample_strobe,
    // rate readings to the block
    output logic [15:0] rate_x,
    output logic [15:0] rate_y
);
    timeunit 1ns;
    timeprecision 1ns;
    // new x reading after each taken sample, y stays at 8001; axes differ so a swap shows
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rate_x <= 16'h1234;
            rate_y <= 16'h8001;
        end
        else if (sample_strobe)
        begin
            rate_x <= rate_x + 16'h0111;
            rate_y <= ~rate_y + 16'h0003;
        end
    end
endmodule

/* bench/grf_setup_properties.sv */
module grf_setup_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_hit,
    // sample and control outputs
    input wire logic sample_strobe,
    input wire logic [15:0] rate_x_out,
    input wire logic lowpass_en,
    input wire logic lowpass_corner_x4,
    input wire logic [13:0] lowpass_bw_hz,
    input wire logic [4:0] highpass_m,
    input wire logic [1:0] range_select,
    input wire logic [11:0] range_dps_x10,
    input wire logic x_selftest
);
    timeunit 1ns;
    timeprecision 1ns;
    // one domain, so one clock and one disable for all
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    hit_needs_read_a: assert property (
        reg_hit |-> $past(reg_rd && ce) && $past(reg_addr) inside {8'h19, 8'h1a, 8'h1b})
        else $error("hit without a mapped read");
    strobe_pulse_a: assert property (
        sample_strobe && ce |=> !sample_strobe) else $error("strobe longer than one cycle");
    out_hold_a: assert property (
        !sample_strobe |-> $stable(rate_x_out)) else $error("output moved between strobes");
    apply_at_sample_a: assert property (
        $changed(range_select) || $changed(lowpass_en) |-> sample_strobe)
        else $error("setting changed off a sample");
    range_map_a: assert property (
        range_dps_x10 == (range_select == 2'h0 ? 12'h1d1 : range_select == 2'h1 ? 12'h3a2 :
        range_select == 2'h2 ? 12'h74e : 12'he9c)) else $error("full scale mismatch");
    m_map_a: assert property (
        highpass_m == 5'h09 || (highpass_m >= 5'h0b && highpass_m <= 5'h11)) else $error("bad m factor");
    bw_base_a: assert property (
        !lowpass_corner_x4 && !lowpass_en |-> lowpass_bw_hz == 14'he10) else $error("bypass bandwidth wrong");
    bw_default_a: assert property (
        lowpass_en && !lowpass_corner_x4 |-> lowpass_bw_hz == 14'h0fa) else $error("default corner wrong");
    selftest_now_a: assert property (
        reg_wr && ce && reg_addr == 8'h1b |=> {x_selftest, 7'h00} == ($past(reg_wdata) & 8'h80))
        else $error("self-test bit not applied");
endmodule

bind grf_setup grf_setup_chk i_grf_setup_chk (
    .mclk(mclk), .srst(srst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_hit(reg_hit), .sample_strobe(sample_strobe), .rate_x_out(rate_x_out),
    .lowpass_en(lowpass_en), .lowpass_corner_x4(lowpass_corner_x4), .lowpass_bw_hz(lowpass_bw_hz),
    .highpass_m(highpass_m), .range_select(range_select), .range_dps_x10(range_dps_x10),
    .x_selftest(x_selftest)
);

/* bench/test_grf_setup.sv */
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("ERROR %0t got %h exp %h", $time, g, e); \
        end \
    end

module test_grf_setup;
    timeunit 1ns;
    timeprecision 1ns;
    // register row: enable, offset, write, readback, hit
    typedef struct {logic c; logic [7:0] a, d, e; logic h;} grf_tb_row_t;
    // mode row: settings, period bounds, expected controls
    typedef struct {logic [7:0] div, cfg, gyr; int lo, hi; logic [13:0] bw; logic [4:0] m;
        grf_pkg::grf_hp_t hs; logic [11:0] dps;} grf_tb_mode_t;
    // stimulus, all valued at time zero
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    // design outputs
    logic [7:0] reg_rdata;
    logic reg_hit, sample_strobe, lowpass_en, lowpass_corner_x4, x_selftest, y_selftest;
    logic [15:0] rate_x_in, rate_y_in, rate_x_out, rate_y_out;
    logic [13:0] lowpass_bw_hz;
    grf_pkg::grf_hp_t highpass_stage_count;
    logic [4:0] highpass_m;
    logic [1:0] range_select;
    logic [11:0] range_dps_x10;
    // bench state
    int bad_count = 0;
    int check_count = 0;
    int n;
    logic [7:0] rdv;
    logic rdh;
    logic [1:0] prev = 2'h0;
    // ce low row must leave the older value
    grf_tb_row_t rows [8] = '{'{1, 8'h19, 8'ha5, 8'ha5, 1}, '{0, 8'h19, 8'h3c, 8'ha5, 1},
        '{1, 8'h1a, 8'hff, 8'h7f, 1}, '{1, 8'h1b, 8'hff, 8'hd9, 1}, '{1, 8'h20, 8'h77, 8'h00, 0},
        '{1, 8'h19, 8'h00, 8'h00, 1}, '{1, 8'h1a, 8'h00, 8'h00, 1}, '{1, 8'h1b, 8'h00, 8'h00, 1}};
    // periods in mclk: a fast tick is 781 or 782 cycles, a base tick four of them
    grf_tb_mode_t modes [4] = '{
        '{8'h01, 8'h7e, 8'h18, 6248, 6256, 14'h0fa, 5'h11, grf_pkg::GRF_HP_TWO, 12'he9c},
        '{8'h00, 8'h40, 8'h11, 781, 782, 14'h22c4, 5'h09, grf_pkg::GRF_HP_ONE, 12'h74e},
        '{8'h02, 8'h26, 8'h09, 6248, 6256, 14'h000, 5'h0b, grf_pkg::GRF_HP_BYPASS, 12'h3a2},
        '{8'h01, 8'h0d, 8'h01, 3124, 3128, 14'hfa0, 5'h0d, grf_pkg::GRF_HP_BYPASS, 12'h1d1}};

    // 25 MHz clock
    always #20 mclk = ~mclk;

    grf_setup i_grf_setup (.mclk(mclk), .srst(srst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .rate_x_in(rate_x_in), .rate_y_in(rate_y_in), .sample_strobe(sample_strobe),
        .rate_x_out(rate_x_out), .rate_y_out(rate_y_out), .lowpass_en(lowpass_en),
        .lowpass_corner_x4(lowpass_corner_x4), .lowpass_bw_hz(lowpass_bw_hz),
        .highpass_stage_count(highpass_stage_count), .highpass_m(highpass_m),
        .range_select(range_select), .range_dps_x10(range_dps_x10), .x_selftest(x_selftest),
        .y_selftest(y_selftest));
    grf_front_model i_grf_front_model (.mclk(mclk), .srst(srst), .sample_strobe(sample_strobe),
        .rate_x(rate_x_in), .rate_y(rate_y_in));

    // one register write, ce chosen per row
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c);
        @(posedge mclk);
        ce <= c;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        ce <= 1'b1;
    endtask

    // one register read; answer is registered on the taking edge and sampled at the next negedge
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rdv = reg_rdata;
        rdh = reg_hit;
    endtask

    // cycles up to the next strobe, bounded so a dead strobe cannot hang
    task automatic next_strobe(output int k);
        k = 0;
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (sample_strobe !== 1'b1 && k < 20000);
    endtask

    // three-cycle reset, then defaults
    task automatic do_reset();
        @(posedge mclk);
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        `CHK(highpass_m, 5'h09)
        `CHK(range_dps_x10, 12'h1d1)
        `CHK(lowpass_bw_hz, 14'he10)
        `CHK({x_selftest, y_selftest, sample_strobe}, 3'h0)
        rd(8'h1b);
        `CHK(rdv, 8'h00)
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d, rows[i].c);
            rd(rows[i].a);
            `CHK(rdv, rows[i].e)
            `CHK(rdh, rows[i].h)
        end
        // new settings wait for a sample, then govern the next period;
        // writes start just after a strobe, so no strobe falls among them
        next_strobe(n);
        foreach (modes[i])
        begin
            wr(8'h19, modes[i].div, 1'b1);
            wr(8'h1a, modes[i].cfg, 1'b1);
            wr(8'h1b, modes[i].gyr, 1'b1);
            @(negedge mclk);
            `CHK(range_select, prev)
            next_strobe(n);
            // after a fast-rate spell the first period may start off a base tick
            next_strobe(n);
            next_strobe(n);
            `CHK(n >= modes[i].lo && n <= modes[i].hi, 1'b1)
            `CHK(rate_x_out, rate_x_in)
            `CHK(rate_y_out, rate_y_in)
            `CHK(lowpass_bw_hz, modes[i].bw)
            `CHK(highpass_m, modes[i].m)
            `CHK(highpass_stage_count, modes[i].hs)
            `CHK(range_dps_x10, modes[i].dps)
            `CHK(range_select, modes[i].gyr[4:3])
            `CHK(lowpass_corner_x4, modes[i].gyr[0])
            `CHK(lowpass_en, modes[i].cfg[1:0] == 2'h2)
            prev = modes[i].gyr[4:3];
        end
        // self-test axes act alone and at once
        wr(8'h1b, 8'h40, 1'b1);
        @(negedge mclk);
        `CHK({x_selftest, y_selftest}, 2'h1)
        wr(8'h1b, 8'h80, 1'b1);
        @(negedge mclk);
        `CHK({x_selftest, y_selftest}, 2'h2)
        next_strobe(n);
        `CHK(rate_x_out, rate_x_in)
        // reset in mid-run
        do_reset();
        stop_test();
    end

    // watchdog: the sequence needs about 53000 cycles
    initial
    begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
endmodule

/* common/grf_consts.svh */
`ifndef GRF_CONSTS_SVH
`define GRF_CONSTS_SVH

// register offsets on the configuration port
`define GRF_ADDR_DIV 8'h19
`define GRF_ADDR_CFG 8'h1a
`define GRF_ADDR_GYR 8'h1b

// reset values
`define GRF_RST_DIV 8'h00
`define GRF_RST_CFG 8'h00
`define GRF_RST_GYR 8'h00

// writable bits; everything else is reserved and reads zero
`define GRF_CFG_MASK 8'h7f
`define GRF_GYR_MASK 8'hd9

// filter_chain_setup field positions
`define GRF_CFG_LP_LSB 0
`define GRF_CFG_LP_MSB 1
`define GRF_CFG_HC_LSB 2
`define GRF_CFG_HC_MSB 4
`define GRF_CFG_HS_LSB 5
`define GRF_CFG_HS_MSB 6

// rate_range_selftest_ctrl field positions
`define GRF_GYR_MODE_BIT 0
`define GRF_GYR_RANGE_LSB 3
`define GRF_GYR_RANGE_MSB 4
`define GRF_GYR_YST_BIT 6
`define GRF_GYR_XST_BIT 7

// timing
`define GRF_MCLK_HZ 25000000
`define GRF_FAST_RATE_HZ 32000
`define GRF_BASE_RATE_HZ 8000
`define GRF_FAST_PER_BASE (`GRF_FAST_RATE_HZ / `GRF_BASE_RATE_HZ)

// low-pass bandwidths in hz
`define GRF_BW_BYP_BASE_HZ 14'd3600
`define GRF_BW_BYP_MODE_HZ 14'd4000
`define GRF_BW_BYP_FAST_HZ 14'd8900
`define GRF_LP_DEFAULT_HZ 14'd250

// high-pass m factor
`define GRF_HP_M_FIRST 5'd9
`define GRF_HP_M_OFFSET 5'd10

// full-scale range in tenths of a degree per second
`define GRF_FS0_DPS_X10 12'd465
`define GRF_FS1_DPS_X10 12'd930
`define GRF_FS2_DPS_X10 12'd1870
`define GRF_FS3_DPS_X10 12'd3740

`endif

/* common/grf_pkg.sv */
`include "grf_consts.svh"

package grf_pkg;

    // high-pass chain arrangement
    typedef enum logic [1:0] {
        GRF_HP_BYPASS,
        GRF_HP_ONE,
        GRF_HP_TWO
    } grf_hp_t;

    // main block state
    typedef struct packed {
        logic [7:0] div;        // rate_divisor register
        logic [7:0] cfg;        // filter_chain_setup register
        logic [7:0] gyr;        // rate_range_selftest_ctrl register
        logic [7:0] act_div;    // settings in force this sample period
        logic act_mode;
        logic [1:0] act_lp;
        logic [1:0] act_hs;
        logic [2:0] act_hc;
        logic [1:0] act_range;
        logic [8:0] cnt;        // base ticks in current period
        logic strobe;           // sample written
        logic [15:0] out_x;     // output registers
        logic [15:0] out_y;
        logic [7:0] rdata;
        logic hit;
    } grf_state_t;

    // base tick generator state
    typedef struct packed {
        logic [24:0] acc;       // fractional phase
        logic [1:0] sub;        // fast ticks within one base tick
        logic t32;
        logic t8;
    } grf_tick_state_t;

endpackage

/* common/grf_tick_if.sv */
interface grf_tick_if;
    logic ce;       // clock enable from the main block
    logic tick32;   // fast rate pulse
    logic tick8;    // base rate pulse, coincident with every fourth fast pulse
    modport gen (input ce, output tick32, output tick8);
    modport sink (output ce, input tick32, input tick8);
endinterface

/* verilog/grf_setup.sv */
`include "grf_consts.svh"

// Contract
// - hold eight-bit unsigned rate divisor
// - mode 0 bypass: 8k/(div+1), 3600 Hz
// - mode 0 filtered: corner from coefficients
// - mode 1 div>=1: 8k/div, 4000 Hz bypass
// - mode 1 div 0: 32 kHz, 8900 bypass
// - lowpass select 0x bypass, 10 enable
// - stage field 0x none, 10 one, 11 two
// - corner code maps to m factor
// - two-bit range selects full scale
// - per-axis independent self-test actuation
// - self-test response lands in output registers
// - control register bit layout fixed
// - default low-pass corner is 250 Hz
// - outputs refreshed once per sample period
module grf_setup (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // register port from the serial engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // sensor front end samples at the fast rate
    input wire logic [15:0] rate_x_in,
    input wire logic [15:0] rate_y_in,
    // output registers
    output logic sample_strobe,
    output logic [15:0] rate_x_out,
    output logic [15:0] rate_y_out,
    // low-pass control
    output logic lowpass_en,
    output logic lowpass_corner_x4,
    output logic [13:0] lowpass_bw_hz,
    // high-pass control
    output grf_pkg::grf_hp_t highpass_stage_count,
    output logic [4:0] highpass_m,
    // range and self-test
    output logic [1:0] range_select,
    output logic [11:0] range_dps_x10,
    output logic x_selftest,
    output logic y_selftest
);

    grf_pkg::grf_state_t s;
    grf_pkg::grf_state_t next_s;
    grf_tick_if tk ();
    logic fast_mode;    // 32 kHz sampling in force
    logic [8:0] period; // base ticks per sample

    // sample period length in base ticks
    function automatic logic [8:0] grf_period(input logic [7:0] div, input logic mode);
        if (mode)
            grf_period = {1'b0, div};
        else
            grf_period = 9'({1'b0, div} + 9'h001);
    endfunction

    // corner code to m factor: 0 is 9, then 11..17
    function automatic logic [4:0] grf_m(input logic [2:0] code);
        if (code == 3'h0)
            grf_m = `GRF_HP_M_FIRST;
        else
            grf_m = `GRF_HP_M_OFFSET + {2'h0, code};
    endfunction

    // full-scale lookup
    function automatic logic [11:0] grf_fs(input logic [1:0] sel);
        case (sel)
            2'h0: grf_fs = `GRF_FS0_DPS_X10;
            2'h1: grf_fs = `GRF_FS1_DPS_X10;
            2'h2: grf_fs = `GRF_FS2_DPS_X10;
            default: grf_fs = `GRF_FS3_DPS_X10;
        endcase
    endfunction

    // base tick source
    grf_tick_gen u_tick (
        .mclk (mclk),
        .srst (srst),
        .tk (tk.gen)
    );

    assign tk.ce = ce;

    // decode of the settings in force, not of the live registers
    assign fast_mode = s.act_mode && (s.act_div == 8'h00);
    assign period = grf_period(s.act_div, s.act_mode);

    // next-state logic
    always_comb
    begin
        next_s = s;
        next_s.strobe = 1'b0;
        next_s.hit = 1'b0;
        // register writes; reserved bits masked off on the way in
        if (reg_wr)
        begin
            unique case (reg_addr)
                `GRF_ADDR_DIV: next_s.div = reg_wdata;
                `GRF_ADDR_CFG: next_s.cfg = reg_wdata & `GRF_CFG_MASK;
                `GRF_ADDR_GYR: next_s.gyr = reg_wdata & `GRF_GYR_MASK;
                default: next_s.div = s.div;                    // unmapped write ignored
            endcase
        end
        // register reads; unmapped offsets answer zero with hit low
        if (reg_rd)
        begin
            unique case (reg_addr)
                `GRF_ADDR_DIV:
                begin
                    next_s.rdata = s.div;
                    next_s.hit = 1'b1;
                end
                `GRF_ADDR_CFG:
                begin
                    next_s.rdata = s.cfg;
                    next_s.hit = 1'b1;
                end
                `GRF_ADDR_GYR:
                begin
                    next_s.rdata = s.gyr;
                    next_s.hit = 1'b1;
                end
                default:
                    next_s.rdata = 8'h00;
            endcase
        end
        // sample timing; >= keeps a shrunk period from running away
        if ((fast_mode && tk.tick32) || (!fast_mode && tk.tick8 && (s.cnt >= 9'(period - 9'h001))))
        begin
            next_s.cnt = 9'h000;
            next_s.strobe = 1'b1;
            // self-test response rides in the normal data path
            next_s.out_x = rate_x_in;
            next_s.out_y = rate_y_in;
            // new settings only at the boundary, so no sample mixes two setups
            next_s.act_div = s.div;
            next_s.act_mode = s.gyr[`GRF_GYR_MODE_BIT];
            next_s.act_lp = s.cfg[`GRF_CFG_LP_MSB:`GRF_CFG_LP_LSB];
            next_s.act_hc = s.cfg[`GRF_CFG_HC_MSB:`GRF_CFG_HC_LSB];
            next_s.act_hs = s.cfg[`GRF_CFG_HS_MSB:`GRF_CFG_HS_LSB];
            next_s.act_range = s.gyr[`GRF_GYR_RANGE_MSB:`GRF_GYR_RANGE_LSB];
        end
        else if (!fast_mode && tk.tick8)
        begin
            next_s.cnt = 9'(s.cnt + 9'h001);
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s <= '0;
            s.div <= `GRF_RST_DIV;
            s.cfg <= `GRF_RST_CFG;
            s.gyr <= `GRF_RST_GYR;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // register port answers
    assign reg_rdata = s.rdata;
    assign reg_hit = s.hit;

    // data path
    assign sample_strobe = s.strobe;
    assign rate_x_out = s.out_x;
    assign rate_y_out = s.out_y;

    // low-pass: only 10 enables; 11 is treated as bypass
    assign lowpass_en = (s.act_lp == 2'b10);
    // filtered corners scale by four in mode 1 (160/320/640)
    assign lowpass_corner_x4 = s.act_mode;

    // bandwidth figure; filtered corners come from the coefficient set,
    // and mode 0 reports the default set's corner
    always_comb
    begin
        if (lowpass_en)
            lowpass_bw_hz = s.act_mode ? 14'h0000 : `GRF_LP_DEFAULT_HZ;
        else if (fast_mode)
            lowpass_bw_hz = `GRF_BW_BYP_FAST_HZ;
        else if (s.act_mode)
            lowpass_bw_hz = `GRF_BW_BYP_MODE_HZ;
        else
            lowpass_bw_hz = `GRF_BW_BYP_BASE_HZ;
    end

    // high-pass arrangement
    always_comb
    begin
        unique case (s.act_hs)
            2'b10: highpass_stage_count = grf_pkg::GRF_HP_ONE;
            2'b11: highpass_stage_count = grf_pkg::GRF_HP_TWO;
            default: highpass_stage_count = grf_pkg::GRF_HP_BYPASS;
        endcase
    end

    assign highpass_m = grf_m(s.act_hc);

    // range
    assign range_select = s.act_range;
    assign range_dps_x10 = grf_fs(s.act_range);

    // self-test actuation follows the register at once, each axis alone
    assign x_selftest = s.gyr[`GRF_GYR_XST_BIT];
    assign y_selftest = s.gyr[`GRF_GYR_YST_BIT];

endmodule

/* verilog/grf_tick_gen.sv */
`include "grf_consts.svh"

module grf_tick_gen (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // ticks out
    grf_tick_if.gen tk
);

    grf_pkg::grf_tick_state_t s;
    grf_pkg::grf_tick_state_t next_s;
    logic [25:0] sum;   // phase plus one step, one bit of headroom

    // phase accumulator: 25 MHz does not divide by 32 kHz, so the pulse
    // spacing dithers 781/782 cycles while the average rate stays exact
    always_comb
    begin
        next_s = s;
        next_s.t32 = 1'b0;
        next_s.t8 = 1'b0;
        sum = {1'b0, s.acc} + 26'(`GRF_FAST_RATE_HZ);
        if (sum >= 26'(`GRF_MCLK_HZ))
        begin
            next_s.acc = 25'(sum - 26'(`GRF_MCLK_HZ));
            next_s.t32 = 1'b1;
            next_s.sub = s.sub + 2'h1;
            // base tick on the last fast tick of each group
            next_s.t8 = (s.sub == 2'(`GRF_FAST_PER_BASE - 1));
        end
        else
        begin
            next_s.acc = sum[24:0];
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk)
    begin
        if (srst)
            s <= '0;
        else if (tk.ce)
            s <= next_s;
    end

    assign tk.tick32 = s.t32;
    assign tk.tick8 = s.t8;

endmodule
